// file: src/dcs_cmd_if.sv
// interface: decoded run commands from control word to status logic
`timescale 1ns/10ps
`default_nettype none
interface dcs_cmd_if;
	logic pos_start;
	logic man_start;
	logic jog_start;
	logic ref_start;
	logic any_start;
	logic abort_release;
	logic man_active;
	logic jog_continuous;
	logic noloop;
	modport ctl (output pos_start, man_start, jog_start, ref_start, any_start, abort_release,
		man_active, jog_continuous, noloop);
	modport sts (input pos_start, man_start, jog_start, ref_start, any_start, abort_release,
		man_active, jog_continuous, noloop);
endinterface : dcs_cmd_if
`default_nettype wire

// file: src/dcs_pkg.sv
// package: constants and types for the drive control/status word block
package dcs_pkg;
	localparam int WORD_W = 16;
	// control word fields
	localparam int CB_MAN_UP    = 0;
	localparam int CB_MAN_DN    = 1;
	localparam int CB_XFER      = 2;
	localparam int CB_JOG_MAN   = 3;
	localparam int CB_RELEASE   = 4;
	localparam int CB_NOLOOP    = 6;
	localparam int CB_REFLOOP   = 7;
	localparam int CB_JOG_UP    = 8;
	localparam int CB_JOG_DN    = 9;
	localparam int CB_READJ     = 10;
	localparam int CB_DRAGCORR  = 12;
	localparam logic [15:0] CTRL_RESERVED_MASK = 16'hE820;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// status word fields
	localparam int SB_TARGET   = 0;
	localparam int SB_DRAG     = 1;
	localparam int SB_MPOWER   = 4;
	localparam int SB_ABORT    = 5;
	localparam int SB_RUNNING  = 6;
	localparam int SB_OVERTEMP = 7;
	localparam int SB_OPPDIR   = 8;
	localparam int SB_MEMERR   = 9;
	localparam int SB_BLOCK    = 10;
	localparam int SB_DISPL    = 11;
	localparam int SB_BADTGT   = 12;
	localparam int SB_PWRMISS  = 13;
	localparam int SB_LIM_POS  = 14;
	localparam int SB_LIM_NEG  = 15;
	localparam logic [15:0] STAT_RESERVED_MASK = 16'h000C;
	localparam logic [15:0] STAT_RESET = 16'h0000;
	localparam logic [7:0] TEMP_HYST_C = 8'h05;
	// jog hold before switching to continuous manual motion
	localparam int JOG_HOLD_NS = 500000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int JOG_HOLD_CYC = (JOG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int JOG_CNT_W = 16;

	typedef enum logic [2:0] {
		DCS_IDLE   = 3'b000,
		DCS_POS    = 3'b001,
		DCS_MAN    = 3'b011,
		DCS_JOG    = 3'b010,
		DCS_REF1   = 3'b110,
		DCS_REF2   = 3'b111
	} dcs_mode_t;

	function automatic logic [15:0] dcs_clean_ctrl(input logic [15:0] w);
		return w & ~CTRL_RESERVED_MASK;
	endfunction : dcs_clean_ctrl
endpackage : dcs_pkg

// file: src/dcs_status.sv
// status word flag set/clear logic
`timescale 1ns/10ps
`default_nettype none
module dcs_status (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	dcs_cmd_if.sts           cmd,
	input  wire logic        target_reached_i,
	input  wire logic        target_far_i,
	input  wire logic        target_invalid_i,
	input  wire logic        target_valid_i,
	input  wire logic        standstill_turned_i,
	input  wire logic        displaced_window_i,
	input  wire logic        speed_short_i,
	input  wire logic        vmot_above_i,
	input  wire logic        rotating_i,
	input  wire logic [7:0]  temp_i,
	input  wire logic [7:0]  temp_limit_i,
	input  wire logic        against_loop_i,
	input  wire logic        fault_i,
	input  wire logic        ref_done_ok_i,
	input  wire logic        overload_abort_i,
	input  wire logic        vmot_drop_i,
	input  wire logic        overcurrent_i,
	input  wire logic        lim_pos_event_i,
	input  wire logic        lim_neg_event_i,
	input  wire logic        pos_abort_i,
	output logic [15:0]      status_o
);
	import dcs_pkg::*;

	typedef struct packed {
		logic [15:0] st;
	} dcs_sts_state_t;

	dcs_sts_state_t r, next_r;
	logic run_start;
	logic [8:0] temp_low;

	assign run_start = cmd.any_start;
	assign temp_low = {1'b0, temp_limit_i} - {1'b0, TEMP_HYST_C};

	always_comb begin
		next_r = r;
		// clear first, then set: a set event in the clearing cycle survives
		if (target_far_i || cmd.man_start || target_invalid_i || standstill_turned_i)
			next_r.st[SB_TARGET] = 1'b0;
		if (target_reached_i)
			next_r.st[SB_TARGET] = 1'b1;
		if (run_start)
			next_r.st[SB_DRAG] = 1'b0;
		if (speed_short_i)
			next_r.st[SB_DRAG] = 1'b1;
		next_r.st[SB_MPOWER] = vmot_above_i;
		if (run_start)
			next_r.st[SB_ABORT] = 1'b0;
		if (pos_abort_i || cmd.abort_release)
			next_r.st[SB_ABORT] = 1'b1;
		next_r.st[SB_RUNNING] = rotating_i;
		if (!temp_low[8] && ({1'b0, temp_i} <= temp_low))
			next_r.st[SB_OVERTEMP] = 1'b0;
		if (temp_i > temp_limit_i)
			next_r.st[SB_OVERTEMP] = 1'b1;
		if ((target_reached_i && !against_loop_i) || ref_done_ok_i)
			next_r.st[SB_OPPDIR] = 1'b0;
		if (against_loop_i && rotating_i)
			next_r.st[SB_OPPDIR] = 1'b1;
		if (ref_done_ok_i)
			next_r.st[SB_MEMERR] = 1'b0;
		if (fault_i)
			next_r.st[SB_MEMERR] = 1'b1;
		if (cmd.pos_start || ref_done_ok_i)
			next_r.st[SB_BLOCK] = 1'b0;
		if (overload_abort_i)
			next_r.st[SB_BLOCK] = 1'b1;
		if (cmd.pos_start || ref_done_ok_i)
			next_r.st[SB_DISPL] = 1'b0;
		if (displaced_window_i && !rotating_i)
			next_r.st[SB_DISPL] = 1'b1;
		if (target_valid_i)
			next_r.st[SB_BADTGT] = 1'b0;
		if (target_invalid_i)
			next_r.st[SB_BADTGT] = 1'b1;
		if ((cmd.pos_start || cmd.ref_start) && vmot_above_i)
			next_r.st[SB_PWRMISS] = 1'b0;
		if (((cmd.pos_start || cmd.ref_start) && !vmot_above_i) || vmot_drop_i
			|| overcurrent_i)
			next_r.st[SB_PWRMISS] = 1'b1;
		if (run_start) begin
			next_r.st[SB_LIM_POS] = 1'b0;
			next_r.st[SB_LIM_NEG] = 1'b0;
		end
		if (lim_pos_event_i)
			next_r.st[SB_LIM_POS] = 1'b1;
		if (lim_neg_event_i)
			next_r.st[SB_LIM_NEG] = 1'b1;
		next_r.st = next_r.st & ~STAT_RESERVED_MASK;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			r <= '{st: STAT_RESET};
		else
			r <= next_r;
	end

	assign status_o = r.st;

	// =====================================================================
	// checks
	property p_target_set;
		@(posedge clk_i) disable iff (!resetn_i)
		target_reached_i |=> status_o[SB_TARGET];
	endproperty
	a_target_set: assert property (p_target_set) else $error("target flag not set");

	property p_drag_clear;
		@(posedge clk_i) disable iff (!resetn_i)
		(run_start && !speed_short_i) |=> !status_o[SB_DRAG];
	endproperty
	a_drag_clear: assert property (p_drag_clear) else $error("drag flag not cleared");

	property p_mpower;
		@(posedge clk_i) disable iff (!resetn_i)
		1'b1 |=> status_o[SB_MPOWER] == $past(vmot_above_i);
	endproperty
	a_mpower: assert property (p_mpower) else $error("power flag mismatch");

	property p_overtemp_hold;
		@(posedge clk_i) disable iff (!resetn_i)
		(status_o[SB_OVERTEMP] && temp_i > temp_low[7:0] && !temp_low[8])
			|=> status_o[SB_OVERTEMP];
	endproperty
	a_overtemp_hold: assert property (p_overtemp_hold) else $error("overtemp lost");

	property p_reserved;
		@(posedge clk_i) disable iff (!resetn_i)
		(status_o & STAT_RESERVED_MASK) == 16'h0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved status bit set");

	property p_badtgt;
		@(posedge clk_i) disable iff (!resetn_i)
		(target_invalid_i ##1 !target_valid_i) |-> status_o[SB_BADTGT];
	endproperty
	a_badtgt: assert property (p_badtgt) else $error("invalid target flag");
endmodule : dcs_status
`default_nettype wire

// file: src/dcs_top.sv
// top: control word register, run command decode and status word
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Summary of operation
// - target-reached bit sets on arrival, clears on far/invalid target, manual run, turning.
// - drag flag sets when speed short after acceleration; any run command clears.
// - motor-power flag follows supply above the motor voltage limit.
// - run-aborted flag sets when release withdrawn mid positioning; next run clears.
// - running flag follows output rotation.
// - over-temperature sets above limit, clears five degrees below limit.
// - opposite-direction flag sets against loop; clears on loop-direction arrival or reference.
// - memory/encoder fault flag blocks runs started from idle except reference loop; loop completion clears.
// - blocking flag sets on overload abort; new positioning or reference clears.
// - displacement flag sets on external turn at standstill; positioning or reference clears.
// - invalid-target flag sets on out-of-range target; valid target clears.
// - power-was-missing flag sets on low voltage or overcurrent; good start clears.
// - range-limit flags set on manual limit, limit change, external push; run clears.
// - control bits 0/1 manual motion, bits 8/9 jog with release clear.
// - cyclic target starts positioning only with transfer bit set.
// - jog gives single steps; with jog-to-manual bit a long hold goes continuous.
// - positioning/manual need release, jog needs it clear; withdrawing aborts run.
// - loop-free bit at positioning start approaches target directly.
// - reference bit runs 5/8 turn against loop, then 5/8 in loop direction.
// - readjust corrects against-loop displacement only; with loop-free, both directions.
// - drag correction trims speed only in positioning acceleration and cruise.
module dcs_top (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// control word access
	input  wire logic        ctrl_we_i,
	input  wire logic [15:0] ctrl_wdata_i,
	output logic [15:0]      ctrl_rdata_o,
	output logic [15:0]      status_o,
	// target handling
	input  wire logic        target_io_i,
	input  wire logic        target_explicit_i,
	input  wire logic        target_in_range_i,
	input  wire logic        target_far_i,
	// motion feedback
	input  wire logic        target_reached_i,
	input  wire logic        standstill_turned_i,
	input  wire logic        displaced_window_i,
	input  wire logic        displaced_against_i,
	input  wire logic        speed_short_i,
	input  wire logic        accel_phase_i,
	input  wire logic        cruise_phase_i,
	input  wire logic        rotating_i,
	input  wire logic        against_loop_i,
	input  wire logic        ref_seg_done_i,
	input  wire logic        ref_fault_i,
	// monitors
	input  wire logic        vmot_above_i,
	input  wire logic [7:0]  temp_i,
	input  wire logic [7:0]  temp_limit_i,
	input  wire logic        fault_i,
	input  wire logic        overload_abort_i,
	input  wire logic        vmot_drop_i,
	input  wire logic        overcurrent_i,
	input  wire logic        lim_pos_event_i,
	input  wire logic        lim_neg_event_i,
	// motion commands
	output logic [2:0]       mode_o,
	output logic             dir_up_o,
	output logic             jog_step_o,
	output logic             loop_free_o,
	output logic             ref_against_o,
	output logic             readjust_o,
	output logic             drag_trim_o
);
	import dcs_pkg::*;

	typedef struct packed {
		logic [15:0]          ctrl;
		dcs_mode_t            mode;
		logic                 dir_up;
		logic                 jog_step;
		logic                 loop_free;
		logic                 readjust;
		logic                 drag_trim;
		logic [JOG_CNT_W-1:0] jog_cnt;
		logic                 jog_cont;
		logic                 pos_abort;
		logic                 ref_ok;
	} dcs_top_state_t;

	dcs_top_state_t r, next_r;
	dcs_cmd_if cmd ();

	logic [15:0] wc;
	logic        rel;
	logic        man_req;
	logic        jog_req;
	logic        new_target;
	logic        memerr;
	logic        tgt_invalid;

	assign wc      = dcs_clean_ctrl(ctrl_wdata_i);
	assign rel     = r.ctrl[CB_RELEASE];
	assign memerr  = status_o[SB_MEMERR];
	// reserved bits are masked so a misbehaving master cannot steer the block
	assign man_req = rel && (r.ctrl[CB_MAN_UP] ^ r.ctrl[CB_MAN_DN]);
	assign jog_req = !rel && (r.ctrl[CB_JOG_UP] ^ r.ctrl[CB_JOG_DN]);
	// cyclic targets need the transfer bit, explicit ones do not
	assign new_target = (target_io_i && r.ctrl[CB_XFER]) || target_explicit_i;
	assign tgt_invalid = new_target && !target_in_range_i;

	always_comb begin
		next_r = r;
		cmd.pos_start = 1'b0;
		cmd.man_start = 1'b0;
		cmd.jog_start = 1'b0;
		cmd.ref_start = 1'b0;
		cmd.abort_release = 1'b0;
		next_r.jog_step = 1'b0;
		next_r.pos_abort = 1'b0;
		next_r.ref_ok = 1'b0;
		if (ctrl_we_i)
			next_r.ctrl = wc;
		case (r.mode)
			DCS_IDLE: begin
				if (r.ctrl[CB_REFLOOP] && rel) begin
					cmd.ref_start = 1'b1;
					next_r.mode = DCS_REF1;
				end else if (!memerr && new_target && target_in_range_i && rel) begin
					cmd.pos_start = 1'b1;
					next_r.mode = DCS_POS;
					next_r.loop_free = r.ctrl[CB_NOLOOP];
				end else if (!memerr && man_req) begin
					cmd.man_start = 1'b1;
					next_r.mode = DCS_MAN;
					next_r.dir_up = r.ctrl[CB_MAN_UP];
				end else if (!memerr && jog_req) begin
					cmd.jog_start = 1'b1;
					next_r.mode = DCS_JOG;
					next_r.dir_up = r.ctrl[CB_JOG_UP];
					next_r.jog_step = 1'b1;
					next_r.jog_cnt = '0;
					next_r.jog_cont = 1'b0;
				end
			end
			DCS_POS: begin
				if (!rel) begin
					next_r.pos_abort = 1'b1;
					next_r.mode = DCS_IDLE;
				end else if (man_req) begin
					cmd.man_start = 1'b1;
					next_r.mode = DCS_MAN;
					next_r.dir_up = r.ctrl[CB_MAN_UP];
				end else if (target_reached_i || overload_abort_i) begin
					next_r.mode = DCS_IDLE;
				end else if (new_target && target_in_range_i) begin
					cmd.pos_start = 1'b1;
				end
			end
			DCS_MAN: begin
				if (!man_req) begin
					cmd.abort_release = !rel;
					next_r.mode = DCS_IDLE;
				end else if (new_target && target_in_range_i) begin
					cmd.pos_start = 1'b1;
					next_r.mode = DCS_POS;
					next_r.loop_free = r.ctrl[CB_NOLOOP];
				end
			end
			DCS_JOG: begin
				if (!jog_req) begin
					next_r.mode = DCS_IDLE;
				end else if (r.ctrl[CB_JOG_MAN] && !r.jog_cont) begin
					if (r.jog_cnt == JOG_CNT_W'(JOG_HOLD_CYC - 1))
						next_r.jog_cont = 1'b1;
					else
						next_r.jog_cnt = r.jog_cnt + 1'b1;
				end
			end
			DCS_REF1: begin
				if (!rel || ref_fault_i)
					next_r.mode = DCS_IDLE;
				else if (ref_seg_done_i)
					next_r.mode = DCS_REF2;
			end
			DCS_REF2: begin
				if (!rel || ref_fault_i) begin
					next_r.mode = DCS_IDLE;
				end else if (ref_seg_done_i) begin
					next_r.ref_ok = 1'b1;
					next_r.mode = DCS_IDLE;
				end
			end
			default: next_r.mode = DCS_IDLE;
		endcase
		// correction only in positioning acceleration or cruise
		next_r.drag_trim = r.ctrl[CB_DRAGCORR] && (next_r.mode == DCS_POS)
			&& (accel_phase_i || cruise_phase_i);
		next_r.readjust = rel && r.ctrl[CB_READJ] && (next_r.mode == DCS_IDLE)
			&& (displaced_against_i || (r.ctrl[CB_NOLOOP] && displaced_window_i));
		cmd.any_start = cmd.pos_start || cmd.man_start || cmd.jog_start || cmd.ref_start;
	end

	assign cmd.man_active = (r.mode == DCS_MAN);
	assign cmd.jog_continuous = r.jog_cont;
	assign cmd.noloop = r.loop_free;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			r <= '{ctrl: CTRL_RESET, mode: DCS_IDLE, jog_cnt: '0, default: 1'b0};
		else
			r <= next_r;
	end

	dcs_status u_status (
		.clk_i              (clk_i),
		.resetn_i           (resetn_i),
		.cmd                (cmd),
		.target_reached_i   (target_reached_i),
		.target_far_i       (target_far_i && new_target),
		.target_invalid_i   (tgt_invalid),
		.target_valid_i     (new_target && target_in_range_i),
		.standstill_turned_i(standstill_turned_i),
		.displaced_window_i (displaced_window_i),
		.speed_short_i      (speed_short_i),
		.vmot_above_i       (vmot_above_i),
		.rotating_i         (rotating_i),
		.temp_i             (temp_i),
		.temp_limit_i       (temp_limit_i),
		.against_loop_i     (against_loop_i),
		.fault_i            (fault_i),
		.ref_done_ok_i      (r.ref_ok),
		.overload_abort_i   (overload_abort_i),
		.vmot_drop_i        (vmot_drop_i),
		.overcurrent_i      (overcurrent_i),
		.lim_pos_event_i    (lim_pos_event_i),
		.lim_neg_event_i    (lim_neg_event_i),
		.pos_abort_i        (r.pos_abort),
		.status_o           (status_o)
	);

	assign ctrl_rdata_o  = r.ctrl;
	assign mode_o        = r.mode;
	assign dir_up_o      = r.dir_up;
	assign jog_step_o    = r.jog_step;
	assign loop_free_o   = r.loop_free;
	assign ref_against_o = (r.mode == DCS_REF1);
	assign readjust_o    = r.readjust;
	assign drag_trim_o   = r.drag_trim;

	// =====================================================================
	// checks
	sequence s_pos_running;
		r.mode == DCS_POS && !rel;
	endsequence
	sequence s_aborted;
		##1 r.pos_abort ##1 status_o[SB_ABORT];
	endsequence
	property p_release_abort;
		@(posedge clk_i) disable iff (!resetn_i)
		s_pos_running |-> s_aborted;
	endproperty
	a_release_abort: assert property (p_release_abort) else $error("no abort");

	property p_memerr_block;
		@(posedge clk_i) disable iff (!resetn_i)
		memerr |-> !cmd.pos_start && !cmd.man_start && !cmd.jog_start;
	endproperty
	a_memerr_block: assert property (p_memerr_block) else $error("run under fault");

	property p_jog_no_release;
		@(posedge clk_i) disable iff (!resetn_i)
		cmd.jog_start |-> !rel;
	endproperty
	a_jog_no_release: assert property (p_jog_no_release) else $error("jog with release");

	property p_xfer;
		@(posedge clk_i) disable iff (!resetn_i)
		(r.mode == DCS_IDLE && target_io_i && !target_explicit_i && !r.ctrl[CB_XFER])
			|-> !cmd.pos_start;
	endproperty
	a_xfer: assert property (p_xfer) else $error("start without transfer bit");

	property p_ref_order;
		@(posedge clk_i) disable iff (!resetn_i)
		(r.mode == DCS_REF2) |-> $past(r.mode == DCS_REF1 || r.mode == DCS_REF2);
	endproperty
	a_ref_order: assert property (p_ref_order) else $error("reference order");

	property p_drag_trim;
		@(posedge clk_i) disable iff (!resetn_i)
		drag_trim_o |-> r.mode == DCS_POS;
	endproperty
	a_drag_trim: assert property (p_drag_trim) else $error("trim outside positioning");

	property p_loopfree;
		@(posedge clk_i) disable iff (!resetn_i)
		(cmd.pos_start && r.mode == DCS_IDLE) |=> loop_free_o == $past(r.ctrl[CB_NOLOOP]);
	endproperty
	a_loopfree: assert property (p_loopfree) else $error("loop-free not latched");

	property p_ctrl_reserved;
		@(posedge clk_i) disable iff (!resetn_i)
		(ctrl_rdata_o & CTRL_RESERVED_MASK) == 16'h0000;
	endproperty
	a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved ctrl bit");

	property p_jog_single;
		@(posedge clk_i) disable iff (!resetn_i)
		(r.mode == DCS_JOG && !r.ctrl[CB_JOG_MAN]) |-> !r.jog_cont;
	endproperty
	a_jog_single: assert property (p_jog_single) else $error("jog went continuous");

	property p_readjust;
		@(posedge clk_i) disable iff (!resetn_i)
		readjust_o |-> $past(r.ctrl[CB_READJ]);
	endproperty
	a_readjust: assert property (p_readjust) else $error("readjust without enable");
endmodule : dcs_top
`default_nettype wire

// file: verif/dcs_master_model.sv
// fieldbus master model: control word writes and cyclic target transfers
`timescale 1ns/10ps
`default_nettype none
module dcs_master_model (
	input  wire logic        clk_i,
	output var logic         ctrl_we_o,
	output var logic [15:0]  ctrl_wdata_o,
	output var logic         target_io_o,
	output var logic         in_range_o
);
	import dcs_pkg::*;
	initial begin
		ctrl_we_o = 1'b0;
		ctrl_wdata_o = 16'h5A5A;
		target_io_o = 1'b0;
		in_range_o = 1'b0;
	end
	// =====================================
	// access tasks, changed on falling edges
	task automatic write_ctrl(input logic [15:0] w);
		@(negedge clk_i);
		ctrl_wdata_o = w & ~CTRL_RESERVED_MASK;
		ctrl_we_o = 1'b1;
		@(negedge clk_i);
		ctrl_we_o = 1'b0;
		// released bus shows garbage, not the last word
		ctrl_wdata_o = ~ctrl_wdata_o;
	endtask : write_ctrl
	task automatic send_target(input logic ok);
		@(negedge clk_i);
		in_range_o = ok;
		target_io_o = 1'b1;
		@(negedge clk_i);
		target_io_o = 1'b0;
	endtask : send_target
endmodule : dcs_master_model
`default_nettype wire

// file: verif/testbench.sv
// testbench: drive control and status word block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk_i, resetn_i, ctrl_we_i, target_io_i, in_range, dir_up_o;
	logic        target_far_i, vmot_above_i, rotating_i, against_loop_i;
	logic [15:0] ctrl_wdata_i, ctrl_rdata_o, status_o, ev;
	logic [7:0]  temp_i, temp_limit_i;
	logic [2:0]  mode_o;
	logic        jog_step_o, loop_free_o, ref_against_o, readjust_o, drag_trim_o;
	int          failures = 0;
	int          comparisons = 0;
	int          cycles = 0;
	// =====================================
	// clock, master model and device
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	dcs_master_model i_master (.clk_i(clk_i), .ctrl_we_o(ctrl_we_i),
		.ctrl_wdata_o(ctrl_wdata_i), .target_io_o(target_io_i), .in_range_o(in_range));
	dcs_top i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ctrl_we_i(ctrl_we_i),
		.ctrl_wdata_i(ctrl_wdata_i), .ctrl_rdata_o(ctrl_rdata_o), .status_o(status_o),
		.target_io_i(target_io_i), .target_explicit_i(ev[13]), .target_in_range_i(in_range),
		.target_far_i(target_far_i), .target_reached_i(ev[1]), .standstill_turned_i(ev[9]),
		.displaced_window_i(ev[10]), .displaced_against_i(ev[11]), .speed_short_i(ev[0]),
		.accel_phase_i(ev[14]), .cruise_phase_i(ev[15]), .rotating_i(rotating_i),
		.against_loop_i(against_loop_i), .ref_seg_done_i(ev[4]), .ref_fault_i(ev[12]),
		.vmot_above_i(vmot_above_i), .temp_i(temp_i), .temp_limit_i(temp_limit_i),
		.fault_i(ev[3]), .overload_abort_i(ev[5]), .vmot_drop_i(ev[6]), .overcurrent_i(ev[7]),
		.lim_pos_event_i(ev[2]), .lim_neg_event_i(ev[8]), .mode_o(mode_o), .dir_up_o(dir_up_o),
		.jog_step_o(jog_step_o), .loop_free_o(loop_free_o), .ref_against_o(ref_against_o),
		.readjust_o(readjust_o), .drag_trim_o(drag_trim_o));
	// =====================================
	// helpers
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick
	task automatic pulse(input int i);
		ev[i] = 1'b1;
		tick(1);
		ev[i] = 1'b0;
		tick(1);
	endtask : pulse
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chkm(input logic [2:0] m);
		chk({13'h0000, mode_o}, {13'h0000, m});
	endtask : chkm
	task automatic chkb(input logic got, input logic exp);
		chk({15'h0000, got}, {15'h0000, exp});
	endtask : chkb
	task automatic test_done();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	// a hang counts as a mismatch; the whole sequence needs about a hundred cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			test_done();
		end
	end
	// =====================================
	// sequence
	initial begin
		ev = 16'h0000;
		resetn_i = 1'b0;
		target_far_i = 1'b0;
		vmot_above_i = 1'b1;
		rotating_i = 1'b0;
		against_loop_i = 1'b0;
		temp_i = 8'h20;
		temp_limit_i = 8'h50;
		tick(4);
		chk(status_o, 16'h0000);
		chk(ctrl_rdata_o, 16'h0000);
		resetn_i = 1'b1;
		tick(2);
		chk(status_o & 16'h005C, 16'h0010);
		rotating_i = 1'b1;
		vmot_above_i = 1'b0;
		tick(2);
		chk(status_o & 16'h0050, 16'h0040);
		rotating_i = 1'b0;
		vmot_above_i = 1'b1;
		temp_i = 8'h51;
		tick(2);
		chk(status_o & 16'h00D0, 16'h0090);
		temp_i = 8'h4C;
		tick(2);
		chk(status_o & 16'h0080, 16'h0080);
		temp_i = 8'h4B;
		tick(2);
		chk(status_o & 16'h0080, 16'h0000);
		pulse(2);
		pulse(8);
		chk(status_o & 16'hC000, 16'hC000);
		i_master.write_ctrl(16'h0014);
		chk(ctrl_rdata_o, 16'h0014);
		i_master.send_target(1'b0);
		tick(1);
		chk(status_o & 16'h1000, 16'h1000);
		chkm(3'b000);
		i_master.send_target(1'b1);
		tick(1);
		chkm(3'b001);
		chk(status_o & 16'hF000, 16'h0000);
		pulse(0);
		chk(status_o & 16'h0002, 16'h0002);
		pulse(1);
		chk(status_o & 16'h0001, 16'h0001);
		chkm(3'b000);
		target_far_i = 1'b1;
		i_master.send_target(1'b1);
		tick(1);
		chk(status_o & 16'h0003, 16'h0000);
		i_master.write_ctrl(16'h0000);
		tick(2);
		chk(status_o & 16'h0020, 16'h0020);
		chkm(3'b000);
		pulse(3);
		chk(status_o & 16'h0200, 16'h0200);
		i_master.write_ctrl(16'h0011);
		tick(2);
		chkm(3'b000);
		i_master.write_ctrl(16'h0090);
		tick(1);
		chkm(3'b110);
		i_master.write_ctrl(16'h0010);
		pulse(4);
		chkm(3'b111);
		chk(status_o & 16'h0020, 16'h0000);
		pulse(4);
		chkm(3'b000);
		tick(2);
		chk(status_o & 16'h0200, 16'h0000);
		i_master.write_ctrl(16'h0011);
		tick(1);
		chkm(3'b011);
		chk({15'h0000, dir_up_o}, 16'h0001);
		rotating_i = 1'b1;
		against_loop_i = 1'b1;
		tick(2);
		chk(status_o & 16'h0100, 16'h0100);
		against_loop_i = 1'b0;
		i_master.write_ctrl(16'h0010);
		i_master.write_ctrl(16'h0012);
		tick(2);
		chk(status_o & 16'h0100, 16'h0100);
		rotating_i = 1'b0;
		i_master.write_ctrl(16'h0000);
		i_master.write_ctrl(16'h0100);
		tick(1);
		chkm(3'b010);
		chkb(jog_step_o, 1'b1);
		tick(1);
		chkb(jog_step_o, 1'b0);
		i_master.write_ctrl(16'h0000);
		i_master.write_ctrl(16'h0110);
		tick(2);
		chkm(3'b000);
		// a reference loop cut short by a fault must not clear the direction flag
		i_master.write_ctrl(16'h0090);
		tick(1);
		chkb(ref_against_o, 1'b1);
		i_master.write_ctrl(16'h0010);
		ev[12] = 1'b1;
		tick(1);
		ev[12] = 1'b0;
		chkm(3'b000);
		chkb(ref_against_o, 1'b0);
		chk(status_o & 16'h0120, 16'h0100);
		// readjust: against the loop only, both ways with loop-free
		i_master.write_ctrl(16'h0410);
		ev[10] = 1'b1;
		tick(1);
		chkb(readjust_o, 1'b0);
		chk(status_o & 16'h0800, 16'h0800);
		ev[10] = 1'b0;
		ev[11] = 1'b1;
		tick(1);
		chkb(readjust_o, 1'b1);
		ev[11] = 1'b0;
		i_master.write_ctrl(16'h1450);
		ev[10] = 1'b1;
		tick(1);
		chkb(readjust_o, 1'b1);
		ev[10] = 1'b0;
		// explicit target, loop-free, drag correction, overload and power events
		target_far_i = 1'b0;
		ev[13] = 1'b1;
		tick(1);
		ev[13] = 1'b0;
		chkm(3'b001);
		chkb(loop_free_o, 1'b1);
		chk(status_o & 16'h0820, 16'h0000);
		ev[14] = 1'b1;
		tick(1);
		chkb(drag_trim_o, 1'b1);
		ev[14] = 1'b0;
		ev[15] = 1'b1;
		tick(1);
		chkb(drag_trim_o, 1'b1);
		ev[15] = 1'b0;
		tick(1);
		chkb(drag_trim_o, 1'b0);
		pulse(5);
		chkm(3'b000);
		chk(status_o & 16'h0400, 16'h0400);
		pulse(6);
		chk(status_o & 16'h2000, 16'h2000);
		ev[13] = 1'b1;
		tick(1);
		ev[13] = 1'b0;
		chk(status_o & 16'h2400, 16'h0000);
		pulse(7);
		chk(status_o & 16'h2000, 16'h2000);
		pulse(1);
		chk(status_o & 16'h0101, 16'h0001);
		pulse(9);
		chk(status_o & 16'h0001, 16'h0000);
		test_done();
	end
endmodule : testbench
`default_nettype wire
